// *** logic/qbm_master.sv ***
// Contract
// - Address driven, then sync held through transfer
// - Data-in during sync reads; wait reply
// - Data-in without sync requests interrupt vector
// - Write/byte asserted at sync leading edge
// - Byte writes keep write/byte with data-out
// - Grant only when priority bit clear
// - Address phase precedes data on shared lines
// - Bank select for top bank, address only
// - Initialize driven while DC power bad
// - Primary power drop starts power-fail trap unless halted
// - Halt ignores interrupts, refresh optionally allowed
// - No reply within timeout aborts cycle
`default_nettype none
module qbm_master
	import qbm_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	// User command port
	input  wire logic              cmd_valid_in,
	input  wire qbm_op_t           cmd_op_in,
	input  wire logic [DATA_W-1:0] cmd_addr_in,
	input  wire logic [DATA_W-1:0] cmd_wdata_in,
	output var  logic              cmd_ready_out,
	output var  logic              done_out,
	output var  logic              timeout_out,
	output var  logic [DATA_W-1:0] rdata_out,
	output var  logic              vector_valid_out,
	output var  logic [DATA_W-1:0] vector_out,
	output var  logic              powerfail_out,
	output var  logic              halted_out,
	input  wire logic [DATA_W-1:0] processor_status_word_in,
	input  wire logic              refresh_in_halt_in,
	input  wire logic              init_req_in,
	// Bus pins
	input  wire logic [DATA_W-1:0] bdal_in,
	output var  logic [DATA_W-1:0] bdal_out,
	output var  logic              bdal_oe_out,
	output var  logic              bsync_n_out,
	output var  logic              bdin_n_out,
	output var  logic              bdout_n_out,
	output var  logic              bwtbt_n_out,
	output var  logic              bbs7_n_out,
	output var  logic              bref_n_out,
	output var  logic              biako_n_out,
	output var  logic              binit_n_out,
	input  wire logic              brply_n_in,
	input  wire logic              birq_n_in,
	input  wire logic              bhalt_n_in,
	input  wire logic              bpok_in,
	input  wire logic              bdcok_in
);
	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	qbm_sync_if sif ();
	assign sif.raw = {bdal_in, bdcok_in, bpok_in, ~bhalt_n_in, ~birq_n_in, ~brply_n_in};

	qbm_sync u_sync (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.sif     (sif)
	);

	logic              brply_s;
	logic              birq_s;
	logic              halt_s;
	logic              pok_s;
	logic              dcok_s;
	logic [DATA_W-1:0] bdal_s;
	assign brply_s = sif.sync[SY_BRPLY];
	assign birq_s  = sif.sync[SY_BIRQ];
	assign halt_s  = sif.sync[SY_BHALT];
	assign pok_s   = sif.sync[SY_BPOK];
	assign dcok_s  = sif.sync[SY_BDCOK];
	assign bdal_s  = sif.sync[SY_BDAL +: DATA_W];

	function automatic logic op_writes(input qbm_op_t op);
		return op == OP_WRITE || op == OP_WRITE_BYTE;
	endfunction

	function automatic logic op_byte(input qbm_op_t op);
		return op == OP_WRITE_BYTE || op == OP_RMW_BYTE;
	endfunction

	// ---------------------------------------------------------------
	// Power, halt and initialize
	// ---------------------------------------------------------------
	logic pok_prev_q;
	logic powerfail_q;
	logic halted_q;
	logic binit_n_q;

	typedef enum {
		ST_IDLE, ST_ADDR, ST_SYNC, ST_DIN, ST_DIN_END, ST_DOUT_SET,
		ST_DOUT, ST_DOUT_END, ST_END, ST_IACK, ST_IACK_END, ST_INIT
	} qbm_state_t;
	qbm_state_t state_q;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pok_prev_q  <= 1'b0;
			powerfail_q <= 1'b0;
			halted_q    <= 1'b0;
		end else begin
			pok_prev_q  <= pok_s;
			powerfail_q <= pok_prev_q && !pok_s && !halted_q;
			halted_q    <= halt_s;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			binit_n_q <= 1'b0;
		end else begin
			binit_n_q <= dcok_s && state_q != ST_INIT;
		end
	end

	// ---------------------------------------------------------------
	// Bus cycle sequencer
	// ---------------------------------------------------------------
	logic [CNT_W-1:0]  cnt_q;
	qbm_op_t           op_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] vector_q;
	logic [DATA_W-1:0] bdal_q;
	logic              bdal_oe_q;
	logic              bsync_n_q;
	logic              bdin_n_q;
	logic              bdout_n_q;
	logic              bwtbt_n_q;
	logic              bbs7_n_q;
	logic              bref_n_q;
	logic              biako_n_q;
	logic              ready_q;
	logic              done_q;
	logic              timeout_q;
	logic              vec_valid_q;
	logic              waiting;
	logic              to_hit;
	logic              may_take;

	assign waiting  = state_q inside {ST_DIN, ST_DIN_END, ST_DOUT, ST_DOUT_END,
		ST_IACK, ST_IACK_END};
	assign to_hit   = waiting && cnt_q == TIMEOUT_CYC - CNT_W'(1);
	assign may_take = cmd_valid_in && ready_q &&
		(!halt_s || (cmd_op_in == OP_REFRESH && refresh_in_halt_in));

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q     <= ST_IDLE;
			cnt_q       <= '0;
			op_q        <= OP_READ;
			wdata_q     <= '0;
			rdata_q     <= '0;
			vector_q    <= '0;
			bdal_q      <= '0;
			bdal_oe_q   <= 1'b0;
			bsync_n_q   <= 1'b1;
			bdin_n_q    <= 1'b1;
			bdout_n_q   <= 1'b1;
			bwtbt_n_q   <= 1'b1;
			bbs7_n_q    <= 1'b1;
			bref_n_q    <= 1'b1;
			biako_n_q   <= 1'b1;
			ready_q     <= 1'b0;
			done_q      <= 1'b0;
			timeout_q   <= 1'b0;
			vec_valid_q <= 1'b0;
		end else begin
			done_q      <= 1'b0;
			timeout_q   <= 1'b0;
			vec_valid_q <= 1'b0;
			cnt_q       <= cnt_q + CNT_W'(1);
			if (to_hit) begin
				// Abort: release every line at once
				state_q   <= ST_IDLE;
				timeout_q <= 1'b1;
				bdal_oe_q <= 1'b0;
				bsync_n_q <= 1'b1;
				bdin_n_q  <= 1'b1;
				bdout_n_q <= 1'b1;
				bwtbt_n_q <= 1'b1;
				bbs7_n_q  <= 1'b1;
				bref_n_q  <= 1'b1;
				biako_n_q <= 1'b1;
			end else begin
				case (state_q)
					ST_IDLE: begin
						cnt_q   <= '0;
						ready_q <= 1'b1;
						if (init_req_in) begin
							ready_q <= 1'b0;
							state_q <= ST_INIT;
						end else if (birq_s && !halt_s &&
							!processor_status_word_in[PSW_PRIO_BIT]) begin
							ready_q   <= 1'b0;
							bdin_n_q  <= 1'b0;
							biako_n_q <= 1'b0;
							state_q   <= ST_IACK;
						end else if (may_take) begin
							ready_q   <= 1'b0;
							op_q      <= cmd_op_in;
							wdata_q   <= cmd_wdata_in;
							bdal_q    <= cmd_addr_in;
							bdal_oe_q <= 1'b1;
							bbs7_n_q  <= cmd_addr_in[DATA_W-1 -: 3] != BANK7_TOP;
							bwtbt_n_q <= !op_writes(cmd_op_in);
							bref_n_q  <= cmd_op_in != OP_REFRESH;
							state_q   <= ST_ADDR;
						end
					end
					ST_ADDR: begin
						if (cnt_q >= ADDR_SETUP_CYC - CNT_W'(1)) begin
							bsync_n_q <= 1'b0;
							cnt_q     <= '0;
							state_q   <= ST_SYNC;
						end
					end
					ST_SYNC: begin
						if (cnt_q >= ADDR_HOLD_CYC - CNT_W'(1)) begin
							cnt_q     <= '0;
							bbs7_n_q  <= 1'b1;
							bwtbt_n_q <= !(op_q == OP_WRITE_BYTE);
							if (op_writes(op_q)) begin
								bdal_q  <= wdata_q;
								state_q <= ST_DOUT_SET;
							end else begin
								bdal_oe_q <= 1'b0;
								bdin_n_q  <= 1'b0;
								state_q   <= ST_DIN;
							end
						end
					end
					ST_DIN: begin
						if (brply_s) begin
							rdata_q  <= bdal_s;
							bdin_n_q <= 1'b1;
							cnt_q    <= '0;
							state_q  <= ST_DIN_END;
						end
					end
					ST_DIN_END: begin
						if (!brply_s) begin
							cnt_q <= '0;
							if (op_q == OP_RMW || op_q == OP_RMW_BYTE) begin
								bdal_q    <= wdata_q;
								bdal_oe_q <= 1'b1;
								bwtbt_n_q <= !op_byte(op_q);
								state_q   <= ST_DOUT_SET;
							end else begin
								state_q <= ST_END;
							end
						end
					end
					ST_DOUT_SET: begin
						if (cnt_q >= DESKEW_CYC - CNT_W'(1)) begin
							bdout_n_q <= 1'b0;
							cnt_q     <= '0;
							state_q   <= ST_DOUT;
						end
					end
					ST_DOUT: begin
						if (brply_s) begin
							bdout_n_q <= 1'b1;
							bdal_oe_q <= 1'b0;
							cnt_q     <= '0;
							state_q   <= ST_DOUT_END;
						end
					end
					ST_DOUT_END: begin
						if (!brply_s) begin
							state_q <= ST_END;
						end
					end
					ST_END: begin
						bsync_n_q <= 1'b1;
						bwtbt_n_q <= 1'b1;
						bref_n_q  <= 1'b1;
						done_q    <= 1'b1;
						state_q   <= ST_IDLE;
					end
					ST_IACK: begin
						if (brply_s) begin
							vector_q  <= bdal_s;
							bdin_n_q  <= 1'b1;
							biako_n_q <= 1'b1;
							cnt_q     <= '0;
							state_q   <= ST_IACK_END;
						end
					end
					ST_IACK_END: begin
						if (!brply_s) begin
							vec_valid_q <= 1'b1;
							state_q     <= ST_IDLE;
						end
					end
					ST_INIT: begin
						if (cnt_q >= INIT_CYC - CNT_W'(1)) begin
							state_q <= ST_IDLE;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign cmd_ready_out    = ready_q;
	assign done_out         = done_q;
	assign timeout_out      = timeout_q;
	assign rdata_out        = rdata_q;
	assign vector_valid_out = vec_valid_q;
	assign vector_out       = vector_q;
	assign powerfail_out    = powerfail_q;
	assign halted_out       = halted_q;
	assign bdal_out         = bdal_q;
	assign bdal_oe_out      = bdal_oe_q;
	assign bsync_n_out      = bsync_n_q;
	assign bdin_n_out       = bdin_n_q;
	assign bdout_n_out      = bdout_n_q;
	assign bwtbt_n_out      = bwtbt_n_q;
	assign bbs7_n_out       = bbs7_n_q;
	assign bref_n_out       = bref_n_q;
	assign biako_n_out      = biako_n_q;
	assign binit_n_out      = binit_n_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_wtbt_at_sync;
		$fell(bsync_n_q) |-> (bwtbt_n_q == !op_writes(op_q));
	endproperty
	a_wtbt_at_sync: assert property (p_wtbt_at_sync)
		else $error("write/byte wrong at sync edge");

	property p_byte_out;
		(!bdout_n_q && op_byte(op_q)) |-> !bwtbt_n_q;
	endproperty
	a_byte_out: assert property (p_byte_out)
		else $error("byte output without write/byte");

	property p_iack_no_sync;
		!biako_n_q |-> (bsync_n_q && !bdin_n_q);
	endproperty
	a_iack_no_sync: assert property (p_iack_no_sync)
		else $error("grant without lone data-in");

	property p_grant_prio;
		$fell(biako_n_q) |-> !$past(processor_status_word_in[PSW_PRIO_BIT]) && !$past(halt_s);
	endproperty
	a_grant_prio: assert property (p_grant_prio)
		else $error("grant while priority set or halted");

	property p_addr_before_sync;
		$fell(bsync_n_q) |-> bdal_oe_q && $past(bdal_oe_q) && $past(bdin_n_q);
	endproperty
	a_addr_before_sync: assert property (p_addr_before_sync)
		else $error("address not driven before sync");

	property p_bank_addr_only;
		!bbs7_n_q |-> (bdin_n_q && bdout_n_q);
	endproperty
	a_bank_addr_only: assert property (p_bank_addr_only)
		else $error("bank select during data phase");

	property p_data_in_sync;
		(!bdout_n_q || (!bdin_n_q && biako_n_q)) |-> !bsync_n_q;
	endproperty
	a_data_in_sync: assert property (p_data_in_sync)
		else $error("data strobe outside sync");

	property p_timeout;
		(waiting && cnt_q == TIMEOUT_CYC - CNT_W'(1)) |=>
			(timeout_out && bdin_n_q && bdout_n_q && biako_n_q && bsync_n_q);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout did not abort cycle");

	property p_init_dcok;
		!dcok_s |=> !binit_n_q;
	endproperty
	a_init_dcok: assert property (p_init_dcok)
		else $error("initialize missing while dc bad");

	property p_read_wait;
		($fell(bdin_n_q) && biako_n_q) |-> !bdin_n_q [*2];
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("data-in dropped before reply");

	c_read:    cover property (done_q && op_q == OP_READ);
	c_byte_wr: cover property (done_q && op_q == OP_WRITE_BYTE);
	c_iack:    cover property (vec_valid_q);
	c_abort:   cover property (timeout_q);
endmodule // qbm_master
`default_nettype wire

// *** logic/qbm_pkg.sv ***
`default_nettype none
package qbm_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TIMEOUT_NS    = 10000;
	localparam int ADDR_SETUP_NS = 150;
	localparam int ADDR_HOLD_NS  = 100;
	localparam int DESKEW_NS     = 150;
	localparam int INIT_NS       = 5000;

	localparam int CNT_W = 10;
	// Longest wait rounds down, least times round up
	localparam logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(TIMEOUT_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] ADDR_SETUP_CYC =
		CNT_W'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] ADDR_HOLD_CYC =
		CNT_W'((ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] DESKEW_CYC =
		CNT_W'((DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] INIT_CYC =
		CNT_W'((INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// Bus layout
	// ---------------------------------------------------------------
	localparam int DATA_W       = 16;
	localparam int PSW_PRIO_BIT = 7;
	localparam logic [2:0] BANK7_TOP = 3'h7;

	// Positions in the synchroniser vector
	localparam int SY_BRPLY = 0;
	localparam int SY_BIRQ  = 1;
	localparam int SY_BHALT = 2;
	localparam int SY_BPOK  = 3;
	localparam int SY_BDCOK = 4;
	localparam int SY_BDAL  = 5;
	localparam int SYNC_W   = SY_BDAL + DATA_W;

	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_WRITE_BYTE,
		OP_RMW,
		OP_RMW_BYTE,
		OP_REFRESH
	} qbm_op_t;

endpackage
`default_nettype wire

// *** logic/qbm_sync_if.sv ***
`default_nettype none
interface qbm_sync_if;
	import qbm_pkg::*;
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] sync;
	modport sync_side (input raw, output sync);
	modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// *** logic/qbm_sync.sv ***
`default_nettype none
module qbm_sync
	import qbm_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	qbm_sync_if.sync_side     sif
);
	// ---------------------------------------------------------------
	// Two-stage synchronisers, one per pin
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_bit
			logic meta_q;
			logic stab_q;
			always_ff @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else begin
					meta_q <= sif.raw[g];
					stab_q <= meta_q;
				end
			end
			assign sif.sync[g] = stab_q;
		end
	endgenerate
endmodule // qbm_sync
`default_nettype wire

// *** tb/qbm_dev_model.sv ***
`default_nettype none
module qbm_dev_model
	import qbm_pkg::*;
#(
	parameter logic [15:0] VECTOR = 16'h00c0
) (
	input  wire logic [15:0] bdal_in,
	input  wire logic        bsync_n_in,
	input  wire logic        bdin_n_in,
	input  wire logic        bdout_n_in,
	input  wire logic        bwtbt_n_in,
	input  wire logic        bbs7_n_in,
	input  wire logic        bref_n_in,
	input  wire logic        biaki_n_in,
	input  wire logic        binit_n_in,
	input  wire logic        irq_set_in,
	input  wire logic        irq_en_in,
	input  wire logic        mute_in,
	input  wire logic [15:0] dly_in,
	output var  logic [15:0] data_out,
	output var  logic        oe_out,
	output var  logic        brply_n_out,
	output wire logic        birq_n_out,
	output wire logic        biako_n_out,
	output var  logic [7:0]  refresh_cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [16];
	logic [15:0] adr_q;
	logic        bank_q;
	logic        irq_q;
	logic        hit;
	logic [3:0]  ix;

	assign birq_n_out  = !(irq_en_in && irq_q);
	// Grant stays blocked while this device presents its vector
	assign biako_n_out = biaki_n_in || irq_q || oe_out;

	// ---------------------------------------------------------------
	// Addressing and request state
	// ---------------------------------------------------------------
	always @(negedge bsync_n_in) begin
		adr_q  = bdal_in;
		bank_q = !bbs7_n_in;
	end
	always @(posedge irq_set_in or negedge binit_n_in) begin
		irq_q = binit_n_in;
	end

	// ---------------------------------------------------------------
	// Slave and vector responder
	// ---------------------------------------------------------------
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 16'h0000;
		data_out = 16'h0000;
		oe_out = 1'b0;
		brply_n_out = 1'b1;
		irq_q = 1'b0;
		refresh_cnt_out = 8'h00;
		forever begin
			@(negedge bdin_n_in or negedge bdout_n_in);
			if (!bdin_n_in && !bsync_n_in && !bref_n_in)
				refresh_cnt_out++;
			#(dly_in);
			hit = !mute_in;
			ix = {bank_q, adr_q[3:1]};
			if (!bdin_n_in && !bsync_n_in) begin
				data_out = mem[ix];
			end else if (!bdin_n_in && !biaki_n_in && irq_q) begin
				data_out = VECTOR;
				irq_q = 1'b0;
			end else if (!bdout_n_in) begin
				#(DESKEW_NS);
				if (hit && (bwtbt_n_in || !adr_q[0]))
					mem[ix][7:0] = bdal_in[7:0];
				if (hit && (bwtbt_n_in || adr_q[0]))
					mem[ix][15:8] = bdal_in[15:8];
			end else begin
				hit = 1'b0;
			end
			if (hit) begin
				oe_out = !bdin_n_in;
				brply_n_out = 1'b0;
				wait (bdin_n_in && bdout_n_in);
				#20;
				oe_out = 1'b0;
				brply_n_out = 1'b1;
			end
		end
	end
endmodule // qbm_dev_model
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top
	import qbm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] VEC = 16'h00c0;
	logic        clk_in, rstn_in, cmd_valid_in, init_req_in, bhalt_n_in, bpok_in, bdcok_in;
	logic        cmd_ready_out, done_out, timeout_out, vector_valid_out, powerfail_out;
	logic        halted_out, bdal_oe_out, bsync_n_out, bdin_n_out, bdout_n_out, bwtbt_n_out;
	logic        bbs7_n_out, bref_n_out, biako_n_out, binit_n_out, brply_n_in, birq_n_in;
	logic        refresh_in_halt_in, dev_oe, nxt_iak_n, irq_set, irq_en, mute, got;
	qbm_op_t     cmd_op_in;
	logic [15:0] cmd_addr_in, cmd_wdata_in, rdata_out, vector_out, processor_status_word_in;
	logic [15:0] bdal_in, bdal_out, dev_data, dly;
	logic [7:0]  ref_cnt;
	int          errors, checks, cyc;

	assign bdal_in = bdal_oe_out ? bdal_out : (dev_oe ? dev_data : 16'h0000);

	qbm_master i_dut (.clk_in, .rstn_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in,
		.cmd_wdata_in, .cmd_ready_out, .done_out, .timeout_out, .rdata_out,
		.vector_valid_out, .vector_out, .powerfail_out, .halted_out,
		.processor_status_word_in, .refresh_in_halt_in, .init_req_in, .bdal_in, .bdal_out,
		.bdal_oe_out, .bsync_n_out, .bdin_n_out, .bdout_n_out, .bwtbt_n_out, .bbs7_n_out,
		.bref_n_out, .biako_n_out, .binit_n_out, .brply_n_in, .birq_n_in, .bhalt_n_in,
		.bpok_in, .bdcok_in);

	qbm_dev_model #(.VECTOR(VEC)) i_dev (.bdal_in(bdal_in), .bsync_n_in(bsync_n_out),
		.bdin_n_in(bdin_n_out), .bdout_n_in(bdout_n_out), .bwtbt_n_in(bwtbt_n_out),
		.bbs7_n_in(bbs7_n_out), .bref_n_in(bref_n_out), .biaki_n_in(biako_n_out),
		.binit_n_in(binit_n_out), .irq_set_in(irq_set), .irq_en_in(irq_en),
		.mute_in(mute), .dly_in(dly), .data_out(dev_data), .oe_out(dev_oe),
		.brply_n_out(brply_n_in), .birq_n_out(birq_n_in), .biako_n_out(nxt_iak_n),
		.refresh_cnt_out(ref_cnt));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic close_out();
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input qbm_op_t op, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		while (cmd_ready_out !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_wdata_in = d;
		cmd_valid_in = 1'b1;
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
		while (done_out !== 1'b1 && timeout_out !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		chk(done_out | timeout_out, 1'b1);
	endtask
	task automatic wait_vec(input int lim);
		got = 1'b0;
		repeat (lim) begin
			@(negedge clk_in);
			if (vector_valid_out === 1'b1)
				got = 1'b1;
		end
	endtask
	task automatic raise_irq();
		irq_set = 1'b1;
		@(negedge clk_in);
		irq_set = 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_rw();
		cmd(OP_WRITE, 16'h0004, 16'h1234);
		chk(done_out, 1'b1);
		cmd(OP_WRITE, 16'he004, 16'habcd);
		cmd(OP_WRITE_BYTE, 16'h0005, 16'h5600);
		cmd(OP_WRITE_BYTE, 16'h0004, 16'h0078);
		cmd(OP_READ, 16'h0004, 16'h0000);
		chk(rdata_out, 16'h5678);
		cmd(OP_READ, 16'he004, 16'h0000);
		chk(rdata_out, 16'habcd);
	endtask
	task automatic t_rmw();
		cmd(OP_RMW, 16'h0004, 16'h9999);
		chk(rdata_out, 16'h5678);
		cmd(OP_RMW_BYTE, 16'he005, 16'h1100);
		chk(rdata_out, 16'habcd);
		cmd(OP_READ, 16'h0004, 16'h0000);
		chk(rdata_out, 16'h9999);
		cmd(OP_READ, 16'he004, 16'h0000);
		chk(rdata_out, 16'h11cd);
	endtask
	task automatic t_refresh_slow();
		logic [7:0] c0;
		c0 = ref_cnt;
		cmd(OP_REFRESH, 16'h0002, 16'h0000);
		chk(ref_cnt, c0 + 8'h01);
		dly = 16'd2000;
		cmd(OP_WRITE, 16'h0006, 16'h4242);
		cmd(OP_READ, 16'h0006, 16'h0000);
		chk(rdata_out, 16'h4242);
		dly = 16'd50;
	endtask
	task automatic t_timeout();
		mute = 1'b1;
		cmd(OP_READ, 16'h0002, 16'h0000);
		chk(timeout_out, 1'b1);
		cmd(OP_WRITE, 16'h0002, 16'h0001);
		chk(timeout_out, 1'b1);
		mute = 1'b0;
	endtask
	task automatic t_irq();
		processor_status_word_in = 16'h0080;
		irq_en = 1'b1;
		raise_irq();
		wait_vec(300);
		chk(got, 1'b0);
		chk(birq_n_in, 1'b0);
		processor_status_word_in = 16'h0000;
		wait_vec(300);
		chk(got, 1'b1);
		chk(vector_out, VEC);
		chk(birq_n_in, 1'b1);
	endtask
	task automatic t_init();
		irq_en = 1'b0;
		raise_irq();
		chk(birq_n_in, 1'b1);
		init_req_in = 1'b1;
		@(negedge clk_in);
		init_req_in = 1'b0;
		repeat (5) @(negedge clk_in);
		chk(binit_n_out, 1'b0);
		repeat (600) @(negedge clk_in);
		irq_en = 1'b1;
		@(negedge clk_in);
		chk(birq_n_in, 1'b1);
		bdcok_in = 1'b0;
		repeat (5) @(negedge clk_in);
		chk(binit_n_out, 1'b0);
		bdcok_in = 1'b1;
		repeat (5) @(negedge clk_in);
		chk(binit_n_out, 1'b1);
	endtask
	task automatic t_halt_pfail();
		logic [7:0] c0;
		bhalt_n_in = 1'b0;
		repeat (10) @(negedge clk_in);
		chk(halted_out, 1'b1);
		refresh_in_halt_in = 1'b1;
		c0 = ref_cnt;
		cmd(OP_REFRESH, 16'h0002, 16'h0000);
		chk(ref_cnt, c0 + 8'h01);
		refresh_in_halt_in = 1'b0;
		raise_irq();
		wait_vec(200);
		chk(got, 1'b0);
		bhalt_n_in = 1'b1;
		wait_vec(300);
		chk(got, 1'b1);
		bpok_in = 1'b0;
		got = 1'b0;
		repeat (20) begin
			@(negedge clk_in);
			if (powerfail_out === 1'b1)
				got = 1'b1;
		end
		chk(got, 1'b1);
		bpok_in = 1'b1;
	endtask

	// ---------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ---------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		{rstn_in, cmd_valid_in, init_req_in, refresh_in_halt_in, irq_set, irq_en, mute} = '0;
		{bhalt_n_in, bpok_in, bdcok_in} = 3'h7;
		cmd_op_in = OP_READ;
		{cmd_addr_in, cmd_wdata_in, processor_status_word_in} = '0;
		dly = 16'd50;
		{errors, checks, cyc} = '0;
		repeat (6) @(negedge clk_in);
		chk(binit_n_out, 1'b0);
		chk(bsync_n_out, 1'b1);
		repeat (6) @(negedge clk_in);
		rstn_in = 1'b1;
		t_rw();
		t_rmw();
		t_refresh_slow();
		t_timeout();
		t_irq();
		t_init();
		t_halt_pfail();
		close_out();
	end
endmodule // tb_top
`default_nettype wire
